// ==== hdl/ncm_pkg.sv ====
// Package: register indices, field layouts and timing constants for the NCO mixer
package ncm_pkg;
    localparam int unsigned ACC_W = 32;
    localparam int unsigned PHASE_W = 16;
    localparam int unsigned SAMPLE_W = 16;
    localparam int unsigned LUT_ADDR_W = 8;
    localparam int unsigned TRIG_W = 16;
    localparam int unsigned REG_ADDR_W = 5;
    // Register indices; the device's register space is addressed by index
    localparam logic [4:0] REG_OUTPUT_CONFIG = 5'h01;
    localparam logic [4:0] REG_PIN_FUNCTION = 5'h03;
    localparam logic [4:0] REG_TUNING_BYTE0 = 5'h10;
    localparam logic [4:0] REG_TUNING_BYTE1 = 5'h11;
    localparam logic [4:0] REG_TUNING_BYTE2 = 5'h12;
    localparam logic [4:0] REG_TUNING_BYTE3 = 5'h13;
    localparam logic [4:0] REG_PHASE_LOW = 5'h14;
    localparam logic [4:0] REG_PHASE_HIGH = 5'h15;
    localparam logic [4:0] REG_UPDATE_CONTROL = 5'h16;
    // Field positions
    localparam int unsigned OUT_DIV_LSB = 0;
    localparam int unsigned MIXER_GAIN_BIT = 2;
    localparam int unsigned SYNC_SEL_LSB = 0;
    localparam logic [1:0] SYNC_SEL_SYNC = 2'h2;
    localparam logic [7:0] UPDATE_MODE_SYNC = 8'hF0;
    localparam logic [7:0] UPDATE_MODE_IMMEDIATE = 8'h00;
    localparam logic [1:0] OUT_DIV_1 = 2'h0;
    localparam logic [1:0] OUT_DIV_2 = 2'h1;
    localparam logic [1:0] OUT_DIV_4 = 2'h2;
    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // Sync-to-accumulator latency in clock cycles
    localparam int unsigned SYNC_LATENCY = 6;
    // Synchroniser front end takes 3 of those cycles
    localparam int unsigned SYNC_FRONT = 3;
    localparam int unsigned SYNC_DELAY = SYNC_LATENCY - SYNC_FRONT;
    typedef enum logic [1:0] {
        NCM_BUF_EMPTY,
        NCM_BUF_ONE,
        NCM_BUF_TWO
    } ncm_buf_state_t;
endpackage

// ==== hdl/ncm_skid_buffer.sv ====
// Two-entry valid/ready buffer for mixed I/Q sample pairs
`timescale 1ns/1ps
`default_nettype none
module ncm_skid_buffer
    import ncm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [2*ncm_pkg::SAMPLE_W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [2*ncm_pkg::SAMPLE_W-1:0] out_data
);
    logic [2*SAMPLE_W-1:0] mem_ff [2];
    logic wr_ptr_ff;
    logic rd_ptr_ff;
    ncm_buf_state_t state_ff;
    logic push;
    logic pop;

    assign in_ready = (state_ff != NCM_BUF_TWO);
    assign out_valid = (state_ff != NCM_BUF_EMPTY);
    assign out_data = mem_ff[rd_ptr_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mem_ff[0] <= '0;
            mem_ff[1] <= '0;
        end else if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= NCM_BUF_EMPTY;
        end else begin
            unique case (state_ff)
                NCM_BUF_EMPTY: begin
                    if (push) begin
                        state_ff <= NCM_BUF_ONE;
                    end
                end
                NCM_BUF_ONE: begin
                    if (push && !pop) begin
                        state_ff <= NCM_BUF_TWO;
                    end else if (pop && !push) begin
                        state_ff <= NCM_BUF_EMPTY;
                    end
                end
                NCM_BUF_TWO: begin
                    if (pop) begin
                        state_ff <= NCM_BUF_ONE;
                    end
                end
                default: begin
                    state_ff <= NCM_BUF_EMPTY;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== hdl/ncm_nco_mixer.sv ====
// NCO with complex mixer, configuration registers and comparator divider
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - 32-bit tuning word, 16-bit phase word
// - Accumulator adds tuning word every cycle
// - acc_clear clears the accumulator
// - Accumulator wraps modulo two to 32
// - Phase offset is phase word over 2^16
// - I=Icos-Qsin, Q=Isin+Qcos, scaled by gain
// - Gain select 0 halves, 1 is unity; clips
// - Sync mode: pin select 10, mode F0
// - Synchronous update leaves accumulator untouched
// - New tuning used six cycles after sync
// - Immediate mode: low tuning byte write transfers
// - Immediate mode: phase low byte write transfers
// - Comparator output divided by 1, 2, 4
// - Sync pin sampled like input data
module ncm_nco_mixer
    import ncm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [ncm_pkg::REG_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_data,
    input wire logic sync_pin,
    input wire logic acc_clear,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [ncm_pkg::SAMPLE_W-1:0] in_i,
    input wire logic [ncm_pkg::SAMPLE_W-1:0] in_q,
    output logic out_valid,
    input wire logic out_ready,
    output logic [ncm_pkg::SAMPLE_W-1:0] out_i,
    output logic [ncm_pkg::SAMPLE_W-1:0] out_q,
    input wire logic comparator_in,
    output logic comparator_out
);
    import ncm_pkg::*;

    logic [7:0] output_config_ff;
    logic [7:0] pin_function_ff;
    logic [ACC_W-1:0] tuning_shadow_ff;
    logic [PHASE_W-1:0] phase_shadow_ff;
    logic [7:0] update_control_ff;
    logic [ACC_W-1:0] tuning_active_ff;
    logic [PHASE_W-1:0] phase_active_ff;
    logic [ACC_W-1:0] acc_ff;
    logic [2:0] sync_sr_ff;
    logic sync_level_ff;
    logic [SYNC_DELAY-1:0] sync_pipe_ff;
    logic [ACC_W-1:0] tuning_pend_ff [SYNC_DELAY];
    logic [PHASE_W-1:0] phase_pend_ff [SYNC_DELAY];
    logic [7:0] nxt_rd_data;
    logic sync_rise;
    logic sync_mode;
    logic immediate_mode;
    logic wr_tuning_low;
    logic wr_phase_low;
    logic apply_sync;
    logic [LUT_ADDR_W-1:0] angle;
    logic signed [TRIG_W-1:0] cos_val;
    logic signed [TRIG_W-1:0] sin_val;
    logic [2*SAMPLE_W-1:0] mix_data;
    logic [2*SAMPLE_W-1:0] buf_out;
    logic stall;
    logic [1:0] div_cnt_ff;
    logic cmp_prev_ff;
    logic cmp_out_ff;

    // Quarter-wave-free sine: full circle by symmetry of a first-quadrant series
    function automatic logic signed [TRIG_W-1:0] sine_of(input logic [LUT_ADDR_W-1:0] a);
        logic [LUT_ADDR_W-3:0] idx;
        logic [LUT_ADDR_W-3:0] mirrored;
        logic signed [31:0] x;
        logic signed [31:0] mag;
        idx = a[LUT_ADDR_W-3:0];
        mirrored = a[LUT_ADDR_W-2] ? (~idx + 6'h01) : idx;
        // Parabolic approximation of sin over a quarter, x in 0..64
        x = (a[LUT_ADDR_W-2] && idx == 6'h00) ? 32'sd64 : 32'(mirrored);
        mag = (x * (32'sd192 - x) * 32'sd32767) / 32'sd8192;
        if (mag > 32'sd32767) begin
            mag = 32'sd32767;
        end
        sine_of = a[LUT_ADDR_W-1] ? TRIG_W'(-mag) : TRIG_W'(mag);
    endfunction

    // Product scaled by the trig full scale, with saturation on the sum
    function automatic logic [SAMPLE_W-1:0] sat_scale(input logic signed [2*SAMPLE_W+1:0] v,
                                                       input logic gain_hi);
        logic signed [2*SAMPLE_W+1:0] s;
        // Trig full scale is 2^15: high gain is unity, low gain one half
        s = gain_hi ? (v >>> (TRIG_W - 1)) : (v >>> TRIG_W);
        if (s > 34'sd32767) begin
            sat_scale = 16'h7FFF;
        end else if (s < -34'sd32768) begin
            sat_scale = 16'h8000;
        end else begin
            sat_scale = s[SAMPLE_W-1:0];
        end
    endfunction

    assign sync_mode = (pin_function_ff[SYNC_SEL_LSB +: 2] == SYNC_SEL_SYNC)
                       && (update_control_ff == UPDATE_MODE_SYNC);
    assign immediate_mode = (update_control_ff == UPDATE_MODE_IMMEDIATE);
    assign wr_tuning_low = reg_wr_en && (reg_addr == REG_TUNING_BYTE0);
    assign wr_phase_low = reg_wr_en && (reg_addr == REG_PHASE_LOW);
    // Second and third stages agree high while the held level was low
    assign sync_rise = sync_sr_ff[1] && sync_sr_ff[2] && !sync_level_ff;
    assign apply_sync = sync_pipe_ff[SYNC_DELAY-1];

    // Three-stage sampler on the sync pin
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sync_sr_ff <= 3'h0;
            sync_level_ff <= 1'b0;
        end else begin
            sync_sr_ff <= {sync_sr_ff[1:0], sync_pin};
            if (sync_sr_ff[1] == sync_sr_ff[2]) begin
                sync_level_ff <= sync_sr_ff[2];
            end
        end
    end

    // Register writes
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            output_config_ff <= RESET_BYTE;
            pin_function_ff <= RESET_BYTE;
            tuning_shadow_ff <= '0;
            phase_shadow_ff <= '0;
            update_control_ff <= RESET_BYTE;
        end else if (reg_wr_en) begin
            unique case (reg_addr)
                REG_OUTPUT_CONFIG: output_config_ff <= reg_wr_data;
                REG_PIN_FUNCTION: pin_function_ff <= reg_wr_data;
                REG_TUNING_BYTE0: tuning_shadow_ff[7:0] <= reg_wr_data;
                REG_TUNING_BYTE1: tuning_shadow_ff[15:8] <= reg_wr_data;
                REG_TUNING_BYTE2: tuning_shadow_ff[23:16] <= reg_wr_data;
                REG_TUNING_BYTE3: tuning_shadow_ff[31:24] <= reg_wr_data;
                REG_PHASE_LOW: phase_shadow_ff[7:0] <= reg_wr_data;
                REG_PHASE_HIGH: phase_shadow_ff[15:8] <= reg_wr_data;
                REG_UPDATE_CONTROL: update_control_ff <= reg_wr_data;
                default: begin
                end
            endcase
        end
    end

    // Register reads; unmapped indices read zero
    always_comb begin
        unique case (reg_addr)
            REG_OUTPUT_CONFIG: nxt_rd_data = output_config_ff;
            REG_PIN_FUNCTION: nxt_rd_data = pin_function_ff;
            REG_TUNING_BYTE0: nxt_rd_data = tuning_shadow_ff[7:0];
            REG_TUNING_BYTE1: nxt_rd_data = tuning_shadow_ff[15:8];
            REG_TUNING_BYTE2: nxt_rd_data = tuning_shadow_ff[23:16];
            REG_TUNING_BYTE3: nxt_rd_data = tuning_shadow_ff[31:24];
            REG_PHASE_LOW: nxt_rd_data = phase_shadow_ff[7:0];
            REG_PHASE_HIGH: nxt_rd_data = phase_shadow_ff[15:8];
            REG_UPDATE_CONTROL: nxt_rd_data = update_control_ff;
            default: nxt_rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rd_data <= 8'h00;
        end else if (reg_rd_en) begin
            reg_rd_data <= nxt_rd_data;
        end
    end

    // Sync path: values captured at the detected edge, applied after the pipe
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sync_pipe_ff <= '0;
            for (int k = 0; k < SYNC_DELAY; k++) begin
                tuning_pend_ff[k] <= '0;
                phase_pend_ff[k] <= '0;
            end
        end else begin
            sync_pipe_ff <= {sync_pipe_ff[SYNC_DELAY-2:0], sync_rise && sync_mode};
            tuning_pend_ff[0] <= tuning_shadow_ff;
            phase_pend_ff[0] <= phase_shadow_ff;
            for (int k = 1; k < SYNC_DELAY; k++) begin
                tuning_pend_ff[k] <= tuning_pend_ff[k-1];
                phase_pend_ff[k] <= phase_pend_ff[k-1];
            end
        end
    end

    // Active tuning and phase words
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tuning_active_ff <= '0;
            phase_active_ff <= '0;
        end else begin
            if (apply_sync) begin
                tuning_active_ff <= tuning_pend_ff[SYNC_DELAY-1];
                phase_active_ff <= phase_pend_ff[SYNC_DELAY-1];
            end
            if (immediate_mode && wr_tuning_low) begin
                tuning_active_ff <= {tuning_shadow_ff[31:8], reg_wr_data};
            end
            if (immediate_mode && wr_phase_low) begin
                phase_active_ff <= {phase_shadow_ff[15:8], reg_wr_data};
            end
        end
    end

    // Phase accumulator; sync-mode updates do not clear it
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            acc_ff <= '0;
        end else if (acc_clear) begin
            acc_ff <= '0;
        end else begin
            // Natural 32-bit wrap
            acc_ff <= acc_ff + tuning_active_ff;
        end
    end

    // Angle = accumulator top + phase top, wrapping a full turn
    assign angle = acc_ff[ACC_W-1 -: LUT_ADDR_W] + phase_active_ff[PHASE_W-1 -: LUT_ADDR_W];
    assign sin_val = sine_of(angle);
    assign cos_val = sine_of(angle + 8'h40);

    // Mixer; gain 0 gives one half, gain 1 unity and may clip
    always_comb begin
        logic signed [2*SAMPLE_W+1:0] pi_;
        logic signed [2*SAMPLE_W+1:0] pq_;
        // Widen before multiplying so the products keep all their bits
        pi_ = 34'(signed'(in_i)) * 34'(cos_val) - 34'(signed'(in_q)) * 34'(sin_val);
        pq_ = 34'(signed'(in_i)) * 34'(sin_val) + 34'(signed'(in_q)) * 34'(cos_val);
        mix_data = {sat_scale(pi_, output_config_ff[MIXER_GAIN_BIT]),
                    sat_scale(pq_, output_config_ff[MIXER_GAIN_BIT])};
    end

    // Stall only affects the sample path; the oscillator keeps running
    assign stall = !in_ready;

    ncm_skid_buffer u_buf (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .in_valid(in_valid && !stall),
        .in_ready(in_ready),
        .in_data(mix_data),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(buf_out)
    );

    assign out_i = buf_out[2*SAMPLE_W-1:SAMPLE_W];
    assign out_q = buf_out[SAMPLE_W-1:0];

    // Comparator divider: follow the input, or toggle every 1 or 2 input rising edges
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt_ff <= 2'h0;
            cmp_prev_ff <= 1'b0;
            cmp_out_ff <= 1'b0;
        end else begin
            cmp_prev_ff <= comparator_in;
            if (output_config_ff[OUT_DIV_LSB +: 2] == OUT_DIV_1) begin
                cmp_out_ff <= comparator_in;
            end else if (comparator_in && !cmp_prev_ff) begin
                div_cnt_ff <= div_cnt_ff + 2'h1;
                if (output_config_ff[OUT_DIV_LSB +: 2] == OUT_DIV_2 || div_cnt_ff[0]) begin
                    cmp_out_ff <= ~cmp_out_ff;
                end
            end
        end
    end

    assign comparator_out = cmp_out_ff;
endmodule
`default_nettype wire

// ==== sim/ncm_nco_mixer_sva.sv ====
// Port-level assertions for the NCO mixer
`timescale 1ns/1ps
`default_nettype none
module ncm_nco_mixer_sva
    import ncm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [ncm_pkg::REG_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic [7:0] reg_rd_data,
    input wire logic in_valid,
    input wire logic in_ready,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [ncm_pkg::SAMPLE_W-1:0] out_i,
    input wire logic [ncm_pkg::SAMPLE_W-1:0] out_q,
    input wire logic comparator_out
);
    logic [1:0] div_ff;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // Shadow of the divider field, so the toggle spacing can be judged
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            div_ff <= OUT_DIV_1;
        end else if (reg_wr_en && reg_addr == REG_OUTPUT_CONFIG) begin
            div_ff <= reg_wr_data[1:0];
        end
    end
    reset_idle_a: assert property ($rose(rst_b) |-> !out_valid && in_ready && reg_rd_data == 8'h00)
        else $error("outputs not idle after reset");
    take_answer_a: assert property (in_valid && in_ready |=> out_valid)
        else $error("taken sample not offered next cycle");
    stall_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_i) && $stable(out_q))
        else $error("output changed during stall");
    full_refuse_a: assert property (!in_ready |-> out_valid)
        else $error("input refused with nothing held");
    unmapped_zero_a: assert property (reg_rd_en && !(reg_addr inside {5'h01, 5'h03, [5'h10:5'h16]})
        |=> reg_rd_data == 8'h00)
        else $error("unmapped read not zero");
    read_stands_a: assert property (!reg_rd_en |=> $stable(reg_rd_data))
        else $error("read data moved without a read");
    phase_readback_a: assert property (
        reg_wr_en && reg_addr == REG_PHASE_HIGH ##1 !reg_wr_en ##1 reg_rd_en && reg_addr == REG_PHASE_HIGH
        |=> reg_rd_data == $past(reg_wr_data, 3))
        else $error("phase high byte readback wrong");
    // Divider toggles are judged only once the field has settled for four cycles
    div_two_a: assert property (div_ff == OUT_DIV_2 && div_ff == $past(div_ff, 4)
        && $changed(comparator_out) |=> $stable(comparator_out))
        else $error("divide by two toggled too soon");
    div_four_a: assert property (div_ff == OUT_DIV_4 && div_ff == $past(div_ff, 4)
        && $changed(comparator_out) |=> $stable(comparator_out)[*3])
        else $error("divide by four toggled too soon");
endmodule
`default_nettype wire

// ==== sim/ncm_sample_src.sv ====
// Upstream sample source offering I/Q pairs under valid/ready
`timescale 1ns/1ps
`default_nettype none
module ncm_sample_src (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [15:0] next_i,
    input wire logic [15:0] next_q,
    input wire logic in_ready,
    output logic in_valid,
    output logic [15:0] in_i,
    output logic [15:0] in_q
);
    // Pair held whole until taken, then the next one is offered
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            in_valid <= 1'b0;
            in_i <= 16'h0000;
            in_q <= 16'h0000;
        end else if (!in_valid || in_ready) begin
            in_valid <= 1'b1;
            in_i <= next_i;
            in_q <= next_q;
        end
    end
endmodule
`default_nettype wire

// ==== sim/test_ncm_nco_mixer.sv ====
// Testbench for the NCO mixer: register tasks and mixing scenarios
`timescale 1ns/1ps
`default_nettype none
module test_ncm_nco_mixer;
    import ncm_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b1;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wr_data = 8'h00;
    logic [7:0] reg_rd_data, rd;
    logic sync_pin = 1'b0;
    logic acc_clear = 1'b0;
    logic out_ready = 1'b1;
    logic comparator_in = 1'b0;
    logic in_valid, in_ready, out_valid, comparator_out, p;
    logic [15:0] in_i, in_q, out_i, out_q, a, b, c, d;
    logic [15:0] src_i = 16'h4000;
    logic [15:0] src_q = 16'h0000;
    int err_count = 0;
    int checks_done = 0;
    int n;
    ncm_nco_mixer u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .sync_pin(sync_pin),
        .acc_clear(acc_clear), .in_valid(in_valid), .in_ready(in_ready), .in_i(in_i), .in_q(in_q),
        .out_valid(out_valid), .out_ready(out_ready), .out_i(out_i), .out_q(out_q),
        .comparator_in(comparator_in), .comparator_out(comparator_out));
    ncm_sample_src u_src (.clk_sys(clk_sys), .rst_b(rst_b), .next_i(src_i), .next_q(src_q),
        .in_ready(in_ready), .in_valid(in_valid), .in_i(in_i), .in_q(in_q));
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) comparator_in <= ~comparator_in;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] near(input logic [15:0] x, input logic [15:0] y);
        return 16'((16'(x - y) + 16'h0002) <= 16'h0004);
    endfunction
    task automatic reg_wr(input logic [4:0] addr, input logic [7:0] data);
        @(posedge clk_sys);
        reg_wr_en <= 1'b1;
        reg_addr <= addr;
        reg_wr_data <= data;
        @(posedge clk_sys);
        reg_wr_en <= 1'b0;
    endtask
    task automatic reg_rd(input logic [4:0] addr, output logic [7:0] data);
        @(posedge clk_sys);
        reg_rd_en <= 1'b1;
        reg_addr <= addr;
        @(posedge clk_sys);
        reg_rd_en <= 1'b0;
        @(negedge clk_sys);
        data = reg_rd_data;
    endtask
    // Upper bytes first so the low-byte write moves a whole word
    task automatic tune(input logic [31:0] w);
        for (int k = 3; k >= 0; k--) reg_wr(REG_TUNING_BYTE0 + 5'(k), w[8*k +: 8]);
    endtask
    task automatic settle;
        repeat (12) @(posedge clk_sys);
    endtask
    task automatic grab(output logic [15:0] v);
        @(negedge clk_sys);
        v = out_i;
    endtask
    task automatic summarize;
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_count++;
        summarize();
    end
    initial begin
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        for (int k = 0; k < 9; k++) begin
            reg_rd(k < 2 ? 5'(1 + 2 * k) : 5'(14 + k), rd);
            check(16'(rd), 16'(RESET_BYTE));
        end
        reg_rd(5'h1F, rd);
        check(16'(rd), 16'h0000);
        for (int k = 2; k < 8; k++) begin
            reg_wr(5'(14 + k), 8'hA0 + 8'(k));
            reg_rd(5'(14 + k), rd);
            check(16'(rd), 16'hA0 + 16'(k));
            reg_wr(5'(14 + k), 8'h00);
        end
        for (int dv = 0; dv < 3; dv++) begin
            reg_wr(REG_OUTPUT_CONFIG, 8'(dv));
            settle();
            n = 0;
            p = comparator_out;
            repeat (64) begin
                @(negedge clk_sys);
                if (comparator_out !== p) n++;
                p = comparator_out;
            end
            check(near(16'(n), 16'(64 >> dv)), 16'h0001);
        end
        reg_wr(REG_OUTPUT_CONFIG, 8'h00);
        @(posedge clk_sys) acc_clear <= 1'b1;
        @(posedge clk_sys) acc_clear <= 1'b0;
        settle();
        grab(a);
        check(out_q, 16'h0000);
        check(16'(!a[15] && a != 16'h0000), 16'h0001);
        // High gain only with half-scale input, so it cannot clip
        reg_wr(REG_OUTPUT_CONFIG, 8'h04);
        settle();
        grab(b);
        check(near(b, a << 1), 16'h0001);
        reg_wr(REG_OUTPUT_CONFIG, 8'h00);
        src_i <= 16'h0000;
        src_q <= 16'h4000;
        settle();
        grab(b);
        check(b, 16'h0000);
        check(out_q, a);
        src_i <= 16'h4000;
        src_q <= 16'h0000;
        // High byte alone must not move the phase
        reg_wr(REG_PHASE_HIGH, 8'h80);
        settle();
        grab(b);
        check(b, a);
        reg_wr(REG_PHASE_LOW, 8'h00);
        settle();
        grab(b);
        check(near(b, -a), 16'h0001);
        reg_wr(REG_PHASE_HIGH, 8'h00);
        reg_wr(REG_PHASE_LOW, 8'h00);
        reg_wr(REG_TUNING_BYTE3, 8'h80);
        settle();
        grab(b);
        check(b, a);
        reg_wr(REG_TUNING_BYTE0, 8'h00);
        settle();
        grab(b);
        grab(c);
        grab(d);
        check(near(c, -b), 16'h0001);
        check(d, b);
        tune(32'h4000_0000);
        settle();
        tune(32'h0000_0000);
        @(posedge clk_sys) acc_clear <= 1'b1;
        @(posedge clk_sys) acc_clear <= 1'b0;
        settle();
        grab(b);
        check(b, a);
        reg_wr(REG_PIN_FUNCTION, 8'(SYNC_SEL_SYNC));
        reg_wr(REG_UPDATE_CONTROL, UPDATE_MODE_SYNC);
        tune(32'h8000_0000);
        settle();
        grab(b);
        grab(c);
        check(c, a);
        @(posedge clk_sys) sync_pin <= 1'b1;
        repeat (SYNC_LATENCY + 4) @(posedge clk_sys);
        grab(b);
        grab(c);
        check(near(c, -b), 16'h0001);
        check(16'(near(b, a) | near(b, -a)), 16'h0001);
        sync_pin <= 1'b0;
        @(posedge clk_sys) out_ready <= 1'b0;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        check(16'(in_ready), 16'h0000);
        check(16'(out_valid), 16'h0001);
        @(posedge clk_sys) out_ready <= 1'b1;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        check(16'(in_ready), 16'h0001);
        summarize();
    end
endmodule
bind ncm_nco_mixer ncm_nco_mixer_sva u_sva (.clk_sys(clk_sys), .rst_b(rst_b), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .in_valid(in_valid), .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready),
    .out_i(out_i), .out_q(out_q), .comparator_out(comparator_out));
`default_nettype wire
